// file: nic_ctrl.sv
// nested priority interrupt controller beside an 8-bit core
// assumes the core reports each finished instruction and acks requests at boundaries
//
// How it works
// - reset and trap are taken whatever the current priority level is.
// - trap entry makes the core stack registers and forces current level 3.
// - reset and trap both end halt mode.
// - executing the trap instruction raises a trap request serviced normally.
// - reset wins over all and leaves the core at level 3.
// - maskable source served only if enabled and above current level, else stays pending.
// - external groups wake from halt; their sensitivity is set by software.
// - edge requests are latched and cleared when their routine is entered.
// - selected pins of one group are ORed onto the group line.
// - peripheral request is its status flag and its enable together.
// - clearing the flag through the peripheral drops a still pending request.
// - any pending source ends wait mode.
// - after halt the first one served must be halt-capable; others follow.
// - concurrent mode lets only reset and trap preempt a routine; nested mode lets higher levels preempt.
// - after reset and trap, lower vector index means higher fixed hardware priority.
// - current level sits in condition-code bits 5 and 3 with codes 10,01,00,11.
// - on entry the current level is loaded from the vector's priority field.
// - enable, disable, halt, wait, return and pop instructions also set the level.
// - four priority registers hold two bits per vector, lowest index lowest.
// - top nibble of the fourth priority register is read-only ones.
// - writing level 0 into a field is ignored; the field keeps its value.
// - raising a running vector's field re-enters it only if still pending.
// - highest software level wins, ties go to fixed hardware priority.
// - requests are accepted only at the end of an instruction.
//
// The implementer's own choices: the address map and the plain strobed port.
`include "nic_consts.svh"
`timescale 1ns/100ps

module nic_ctrl (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // external pins, four groups of four, and their selection
    input  wire logic [15:0] ext_pin,
    input  wire logic [15:0] ext_pin_sel,
    // peripheral flags and enables, one per vector
    input  wire logic [13:0] periph_flag,
    input  wire logic [13:0] periph_en,
    // core side
    input  wire logic        instr_done,
    input  wire logic [2:0]  instr_op,
    input  wire logic [7:0]  cc_pop_data,
    input  wire logic        int_ack,
    output logic             int_req,
    output logic      [3:0]  int_vec,
    output logic             int_push,
    output logic             cur_prio_high_bit,
    output logic             cur_prio_low_bit,
    output logic             core_run
);

    logic [27:0]          prio_r;
    logic [7:0]           sense_r;
    logic                 nested_r;
    logic [1:0]           cur_r;
    logic [3:0]           depth_r;
    logic                 reset_pend_r;
    logic                 trap_pend_r;
    logic                 halt_exit_r;
    nic_pkg::nic_lp_t     lp_r;
    logic [3:0]           grp_prev_r;
    logic [3:0]           edge_lat_r;
    logic [3:0]           grp_line;
    logic [3:0]           grp_edge;
    logic [3:0]           grp_level;
    logic [13:0]          pend;
    logic [13:0]          qual;
    logic [1:0]           lvl [14];
    logic [1:0]           cur_lvl;
    logic                 win_valid;
    logic [3:0]           win_vec;
    logic [1:0]           win_lvl;
    logic                 take;
    logic                 op_ok;
    nic_pkg::nic_op_t     op;
    logic [7:0]           rdata_nxt;
    logic [13:0]          halt_cap;

    // level code 10,01,00,11 maps to 0,1,2,3
    function automatic logic [1:0] code2lvl(input logic [1:0] c);
        code2lvl = {~(c[1] ^ c[0]), c[0]};
    endfunction : code2lvl

    assign op      = nic_pkg::nic_op_t'(instr_op);
    assign op_ok   = instr_done && lp_r == nic_pkg::NIC_LP_RUN;
    assign cur_lvl = code2lvl(cur_r);
    assign take    = int_ack && int_req && instr_done;
    assign halt_cap = `NIC_HALT_MASK;

    // external groups: OR of selected pins, edge and level detection
    genvar g;
    generate
        for (g = 0; g < `NIC_NGRP; g++) begin : g_grp
            logic [1:0] s;
            assign s           = sense_r[2*g+1:2*g];
            assign grp_line[g] = |(ext_pin[4*g+3:4*g] & ext_pin_sel[4*g+3:4*g]);
            assign grp_edge[g] = (s == 2'h1 && grp_line[g] && !grp_prev_r[g])
                              || ((s == 2'h0 || s == 2'h2) && !grp_line[g] && grp_prev_r[g])
                              || (s == 2'h3 && grp_line[g] != grp_prev_r[g]);
            assign grp_level[g] = (s == 2'h0) && !grp_line[g] && |ext_pin_sel[4*g+3:4*g];

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    edge_lat_r[g] <= 1'b0;
                end else if (grp_edge[g]) begin
                    edge_lat_r[g] <= 1'b1;
                end else if (take && int_vec == 4'(`NIC_EXT_BASE + g)) begin
                    edge_lat_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            grp_prev_r <= 4'h0;
        end else begin
            grp_prev_r <= grp_line;
        end
    end

    // per-vector pending, level and qualification
    genvar v;
    generate
        for (v = 0; v < `NIC_NVEC; v++) begin : g_vec
            logic ok;
            assign lvl[v] = code2lvl(prio_r[2*v+1:2*v]);
            if (v >= `NIC_EXT_BASE && v < `NIC_EXT_BASE + `NIC_NGRP) begin : g_e
                assign pend[v] = edge_lat_r[v-`NIC_EXT_BASE] || grp_level[v-`NIC_EXT_BASE];
            end else begin : g_p
                assign pend[v] = periph_flag[v] && periph_en[v];
            end
            assign ok      = !halt_exit_r || halt_cap[v];
            assign qual[v] = pend[v] && ok && lvl[v] > cur_lvl
                          && (nested_r || depth_r == 4'h0);
        end
    endgenerate

    // arbitration: reset, then trap, then best level, ties to lowest index
    always_comb begin
        win_valid = 1'b0;
        win_vec   = 4'h0;
        win_lvl   = 2'h0;
        for (int i = `NIC_NVEC - 1; i >= 0; i--) begin
            if (qual[i] && (!win_valid || lvl[i] >= win_lvl)) begin
                win_valid = 1'b1;
                win_vec   = 4'(i);
                win_lvl   = lvl[i];
            end
        end
        if (trap_pend_r) begin
            win_valid = 1'b1;
            win_vec   = `NIC_VEC_TRAP;
        end
        if (reset_pend_r) begin
            win_valid = 1'b1;
            win_vec   = `NIC_VEC_RESET;
        end
    end

    // request to the core, held only while running
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_req  <= 1'b0;
            int_vec  <= 4'h0;
            int_push <= 1'b0;
        end else begin
            int_req  <= win_valid && !take && lp_r == nic_pkg::NIC_LP_RUN;
            int_vec  <= win_vec;
            int_push <= win_vec != `NIC_VEC_RESET;
        end
    end

    // non-maskable pending flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pend_r <= 1'b1;
            trap_pend_r  <= 1'b0;
        end else begin
            if (take && int_vec == `NIC_VEC_RESET) begin
                reset_pend_r <= 1'b0;
            end
            if (op_ok && op == nic_pkg::NIC_OP_TRAP) begin
                trap_pend_r <= 1'b1;
            end else if (take && int_vec == `NIC_VEC_TRAP) begin
                trap_pend_r <= 1'b0;
            end
        end
    end

    // current software level
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_r <= `NIC_CODE_LVL3;
        end else if (take) begin
            if (int_vec == `NIC_VEC_RESET || int_vec == `NIC_VEC_TRAP) begin
                cur_r <= `NIC_CODE_LVL3;
            end else begin
                cur_r <= prio_r[2*int_vec+1 -: 2];
            end
        end else if (op_ok) begin
            unique case (op)
                nic_pkg::NIC_OP_RIM,
                nic_pkg::NIC_OP_HALT,
                nic_pkg::NIC_OP_WFI:   cur_r <= `NIC_CODE_LVL0;
                nic_pkg::NIC_OP_SIM:   cur_r <= `NIC_CODE_LVL3;
                nic_pkg::NIC_OP_IRQ_RETURN_INSTR,
                nic_pkg::NIC_OP_POPCC: cur_r <= {cc_pop_data[`NIC_CC_HI], cc_pop_data[`NIC_CC_LO]};
                default:               cur_r <= cur_r;
            endcase
        end
    end

    assign cur_prio_high_bit = cur_r[1];
    assign cur_prio_low_bit  = cur_r[0];

    // routine depth for concurrent mode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            depth_r <= 4'h0;
        end else if (take && int_vec != `NIC_VEC_RESET) begin
            depth_r <= depth_r + 4'h1;
        end else if (op_ok && op == nic_pkg::NIC_OP_IRQ_RETURN_INSTR && depth_r != 4'h0) begin
            depth_r <= depth_r - 4'h1;
        end
    end

    // low-power modes and wake-up
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_r        <= nic_pkg::NIC_LP_RUN;
            halt_exit_r <= 1'b0;
            core_run    <= 1'b1;
        end else begin
            unique case (lp_r)
                nic_pkg::NIC_LP_RUN: begin
                    if (op_ok && op == nic_pkg::NIC_OP_HALT) begin
                        lp_r     <= nic_pkg::NIC_LP_HALT;
                        core_run <= 1'b0;
                    end else if (op_ok && op == nic_pkg::NIC_OP_WFI) begin
                        lp_r     <= nic_pkg::NIC_LP_WAIT;
                        core_run <= 1'b0;
                    end
                    if (take) begin
                        halt_exit_r <= 1'b0;
                    end
                end
                nic_pkg::NIC_LP_WAIT: begin
                    if (|pend || trap_pend_r || reset_pend_r) begin
                        lp_r     <= nic_pkg::NIC_LP_RUN;
                        core_run <= 1'b1;
                    end
                end
                nic_pkg::NIC_LP_HALT: begin
                    if (|(pend & `NIC_HALT_MASK) || trap_pend_r || reset_pend_r) begin
                        lp_r        <= nic_pkg::NIC_LP_RUN;
                        core_run    <= 1'b1;
                        halt_exit_r <= |(pend & `NIC_HALT_MASK);
                    end
                end
            endcase
        end
    end

    // register writes
    genvar f;
    generate
        for (f = 0; f < `NIC_NVEC; f++) begin : g_fld
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    prio_r[2*f+1:2*f] <= `NIC_CODE_LVL3;
                end else if (reg_wr && reg_addr == 3'(f / 4)
                             && reg_wdata[2*(f%4)+1:2*(f%4)] != `NIC_CODE_LVL0) begin
                    prio_r[2*f+1:2*f] <= reg_wdata[2*(f%4)+1:2*(f%4)];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_r  <= `NIC_SENSE_RST;
            nested_r <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `NIC_ADDR_SENSE && cur_r == `NIC_CODE_LVL3) begin
                sense_r <= reg_wdata;
            end
            if (reg_addr == `NIC_ADDR_CTRL) begin
                nested_r <= reg_wdata[0];
            end
        end
    end

    // register reads, data one cycle after the strobe
    always_comb begin
        unique case (reg_addr)
            `NIC_ADDR_PRIO0: rdata_nxt = prio_r[7:0];
            `NIC_ADDR_PRIO1: rdata_nxt = prio_r[15:8];
            `NIC_ADDR_PRIO2: rdata_nxt = prio_r[23:16];
            `NIC_ADDR_PRIO3: rdata_nxt = {`NIC_PRIO3_RO, prio_r[27:24]};
            `NIC_ADDR_SENSE: rdata_nxt = sense_r;
            `NIC_ADDR_CTRL:  rdata_nxt = {7'h00, nested_r};
            `NIC_ADDR_STAT:  rdata_nxt = {1'b0, lp_r, depth_r != 4'h0, halt_exit_r, cur_r};
            default:         rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
        end
    end

    // checks
    reset_first_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        reset_pend_r && lp_r == nic_pkg::NIC_LP_RUN && !take |=> int_req && int_vec == `NIC_VEC_RESET)
        else $error("reset request not presented");
    nmi_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && int_vec >= `NIC_VEC_TRAP |=> cur_r == `NIC_CODE_LVL3)
        else $error("level not forced to 3 on trap or reset");
    entry_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && int_vec < 4'(`NIC_NVEC) |=> cur_r == $past(prio_r[2*int_vec+1 -: 2]))
        else $error("level not loaded from vector field");
    trap_raise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        op_ok && op == nic_pkg::NIC_OP_TRAP |=> trap_pend_r ##1 int_req || trap_pend_r)
        else $error("trap not raised");
    mask_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        win_valid && win_vec < 4'(`NIC_NVEC) |-> pend[win_vec] && lvl[win_vec] > cur_lvl)
        else $error("masked source requested");
    concurrent_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !nested_r && depth_r != 4'h0 && !trap_pend_r && !reset_pend_r |=> !int_req || int_vec >= `NIC_VEC_TRAP)
        else $error("preemption in concurrent mode");
    wait_wake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        lp_r == nic_pkg::NIC_LP_WAIT && |pend |=> lp_r == nic_pkg::NIC_LP_RUN && core_run)
        else $error("wait not left on pending source");
    halt_first_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        int_req && halt_exit_r && int_vec < 4'(`NIC_NVEC) |-> halt_cap[int_vec])
        else $error("non halt-capable served first after halt");
    prio3_ones_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == `NIC_ADDR_PRIO3 |=> reg_rdata[7:4] == `NIC_PRIO3_RO)
        else $error("read-only nibble not ones");
    no_lvl0_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        prio_r[1:0] != `NIC_CODE_LVL0 ##1 1'b1 |-> prio_r[1:0] != `NIC_CODE_LVL0)
        else $error("level 0 stored in a field");

    nested_cov: cover property (@(posedge core_clk) disable iff (!rst_n)
        nested_r && take && depth_r != 4'h0);
    halt_wake_cov: cover property (@(posedge core_clk) disable iff (!rst_n)
        lp_r == nic_pkg::NIC_LP_HALT ##1 lp_r == nic_pkg::NIC_LP_RUN);
    trap_cov: cover property (@(posedge core_clk) disable iff (!rst_n)
        take && int_vec == `NIC_VEC_TRAP);

endmodule : nic_ctrl

// file: nic_consts.svh
// constants of the nested priority interrupt controller
// included by nic_ctrl.sv and the bench, not by nic_pkg.sv; definitions only
`ifndef NIC_CONSTS_SVH
`define NIC_CONSTS_SVH

// register offsets on the plain register port
`define NIC_ADDR_PRIO0   3'h0
`define NIC_ADDR_PRIO1   3'h1
`define NIC_ADDR_PRIO2   3'h2
`define NIC_ADDR_PRIO3   3'h3
`define NIC_ADDR_SENSE   3'h4
`define NIC_ADDR_CTRL    3'h5
`define NIC_ADDR_STAT    3'h6

// reset values
`define NIC_PRIO_RST     8'hFF
`define NIC_SENSE_RST    8'h00
`define NIC_PRIO3_RO     4'hF

// condition-code priority bit positions and level codes
`define NIC_CC_HI        5
`define NIC_CC_LO        3
`define NIC_CODE_LVL0    2'h2
`define NIC_CODE_LVL3    2'h3

// vectors
`define NIC_NVEC         14
`define NIC_NGRP         4
`define NIC_EXT_BASE     2
`define NIC_VEC_RESET    4'hF
`define NIC_VEC_TRAP     4'hE
`define NIC_HALT_MASK    14'h00BC

`endif

// file: nic_pkg.sv
// types of the nested priority interrupt controller
// constants live in nic_consts.svh
package nic_pkg;

    // instruction reported by the core at an instruction boundary
    typedef enum logic [2:0] {
        NIC_OP_NONE  = 3'h0,
        NIC_OP_RIM   = 3'h1,
        NIC_OP_SIM   = 3'h2,
        NIC_OP_HALT  = 3'h3,
        NIC_OP_WFI   = 3'h4,
        NIC_OP_IRQ_RETURN_INSTR  = 3'h5,
        NIC_OP_POPCC = 3'h6,
        NIC_OP_TRAP  = 3'h7
    } nic_op_t;

    // low-power state of the core
    typedef enum logic [2:0] {
        NIC_LP_RUN  = 3'h1,
        NIC_LP_WAIT = 3'h2,
        NIC_LP_HALT = 3'h4
    } nic_lp_t;

endpackage : nic_pkg

// file: nic_core_model.sv
// behavioural core beside the interrupt controller: runs instructions and enters routines
// assumes the controller's registered request outputs and one core_clk domain
`timescale 1ns/100ps

module nic_core_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // controller side
    input  wire logic       int_req,
    input  wire logic [3:0] int_vec,
    input  wire logic       int_push,
    input  wire logic       cur_hi,
    input  wire logic       cur_lo,
    input  wire logic       core_run,
    output logic            instr_done,
    output logic      [2:0] instr_op,
    output logic      [7:0] cc_pop_data,
    output logic            int_ack,
    // bench commands and status
    input  wire logic       slow,
    input  wire logic       op_go,
    input  wire logic [2:0] op_code,
    input  wire logic [1:0] pop_code,
    input  wire logic       ack_go,
    output logic            op_pend,
    output logic      [7:0] ack_cnt,
    output logic      [3:0] last_vec,
    output logic            last_push
);
    logic [2:0] op_r;
    logic       arm_r;
    logic [1:0] gap_r;
    logic [2:0] sp_r;
    logic [1:0] stk_r [0:7];
    logic [1:0] code;

    // return pops the saved level, a plain pop takes the bench value
    assign code = (instr_op == nic_pkg::NIC_OP_IRQ_RETURN_INSTR) ? stk_r[sp_r] : pop_code;
    assign cc_pop_data = {2'h3, code[1], 1'h0, code[0], 3'h2};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_done <= 1'h0;
            instr_op   <= nic_pkg::NIC_OP_NONE;
            int_ack    <= 1'h0;
            op_pend    <= 1'h0;
            arm_r      <= 1'h0;
            gap_r      <= 2'h0;
            sp_r       <= 3'h0;
            ack_cnt    <= 8'h00;
            last_vec   <= 4'h0;
            last_push  <= 1'h0;
        end else begin
            instr_done <= 1'h0;
            int_ack    <= 1'h0;
            instr_op   <= nic_pkg::NIC_OP_NONE;
            gap_r      <= gap_r + 2'h1;
            // entry counts only with the request still up at the boundary
            if (instr_done && int_ack && int_req) begin
                ack_cnt   <= ack_cnt + 8'h01;
                last_vec  <= int_vec;
                last_push <= int_push;
                if (int_push) begin
                    stk_r[sp_r] <= {cur_hi, cur_lo};
                    sp_r        <= sp_r + 3'h1;
                end
            end
            // slow mode finishes an instruction every fourth cycle
            if (core_run && !instr_done && (!slow || gap_r == 2'h0)) begin
                instr_done <= 1'h1;
                if (int_req && arm_r) begin
                    int_ack <= 1'h1;
                    arm_r   <= 1'h0;
                end else if (op_pend) begin
                    instr_op <= op_r;
                    op_pend  <= 1'h0;
                    if (op_r == nic_pkg::NIC_OP_IRQ_RETURN_INSTR) begin
                        sp_r <= sp_r - 3'h1;
                    end
                end
            end
            if (op_go) begin
                op_r    <= op_code;
                op_pend <= 1'h1;
            end
            if (ack_go) begin
                arm_r <= 1'h1;
            end
        end
    end
endmodule : nic_core_model

// file: test_nic_ctrl.sv
// self-checking bench for nic_ctrl driven through a behavioural core
// assumes nic_pkg, nic_consts.svh, nic_ctrl and nic_core_model are compiled
`timescale 1ns/100ps
`include "nic_consts.svh"

module test_nic_ctrl;
    logic        core_clk;
    logic        rst_n = 1'h0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'h0;
    logic        reg_rd = 1'h0;
    logic [15:0] ext_pin = 16'hFFFF;
    logic [15:0] ext_pin_sel = 16'h0000;
    logic [13:0] periph_flag = 14'h0000;
    logic [13:0] periph_en = 14'h0000;
    logic        slow = 1'h0;
    logic        op_go = 1'h0;
    logic        ack_go = 1'h0;
    logic [2:0]  op_code = 3'h0;
    logic [1:0]  pop_code = 2'h0;
    logic [7:0]  reg_rdata, cc_pop_data, ack_cnt;
    logic [2:0]  instr_op;
    logic [3:0]  int_vec, last_vec;
    logic        instr_done, int_ack, int_req, int_push, cur_hi, cur_lo, core_run, op_pend, last_push;
    logic [1:0]  cur;
    int          err_count = 0;
    int          n_tests = 0;
    int          cycles = 0;

    assign cur = {cur_hi, cur_lo};

    nic_ctrl nic_ctrl_inst (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
        .ext_pin_sel(ext_pin_sel), .periph_flag(periph_flag), .periph_en(periph_en),
        .instr_done(instr_done), .instr_op(instr_op), .cc_pop_data(cc_pop_data),
        .int_ack(int_ack), .int_req(int_req), .int_vec(int_vec), .int_push(int_push),
        .cur_prio_high_bit(cur_hi), .cur_prio_low_bit(cur_lo), .core_run(core_run)
    );

    nic_core_model nic_core_model_inst (
        .core_clk(core_clk), .rst_n(rst_n), .int_req(int_req), .int_vec(int_vec),
        .int_push(int_push), .cur_hi(cur_hi), .cur_lo(cur_lo), .core_run(core_run),
        .instr_done(instr_done), .instr_op(instr_op), .cc_pop_data(cc_pop_data),
        .int_ack(int_ack), .slow(slow), .op_go(op_go), .op_code(op_code), .pop_code(pop_code),
        .ack_go(ack_go), .op_pend(op_pend), .ack_cnt(ack_cnt), .last_vec(last_vec),
        .last_push(last_push)
    );

    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge core_clk);
        reg_wr    <= 1'h0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge core_clk);
        reg_rd   <= 1'h0;
        @(negedge core_clk);
        chk(16'(reg_rdata), 16'(exp));
    endtask : rd

    // one instruction through the core, then time for its effect to land
    task automatic op(input logic [2:0] o);
        int n;
        n = 0;
        @(posedge core_clk);
        op_code <= o;
        op_go   <= 1'h1;
        @(posedge core_clk);
        op_go   <= 1'h0;
        @(negedge core_clk);
        while (op_pend === 1'h1 && n < 40) begin
            n++;
            @(negedge core_clk);
        end
        chk(16'(op_pend), 16'h0000);
        cyc(3);
    endtask : op

    task automatic want(input logic [3:0] v);
        int n;
        n = 0;
        while (int_req !== 1'h1 && n < 30) begin
            n++;
            @(negedge core_clk);
        end
        chk(16'({int_req, int_vec}), 16'({1'h1, v}));
    endtask : want

    // let the core enter one routine, then compare vector and new level
    task automatic take(input logic [3:0] v, input logic [1:0] c);
        int n;
        logic [7:0] k;
        n = 0;
        k = ack_cnt;
        @(posedge core_clk);
        ack_go <= 1'h1;
        @(posedge core_clk);
        ack_go <= 1'h0;
        while (ack_cnt === k && n < 40) begin
            n++;
            @(negedge core_clk);
        end
        cyc(2);
        chk(16'({last_vec, cur}), 16'({v, c}));
    endtask : take

    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'h1;
        cyc(2);
        chk(16'({int_req, int_vec, int_push, cur, core_run}), 16'h01F7);
        for (int i = 0; i < 4; i++) begin
            rd(3'(i), 8'hFF);
        end
        rd(`NIC_ADDR_SENSE, 8'h00);
        rd(3'h7, 8'h00);
        take(4'hF, 2'h3);
        chk(16'(last_push), 16'h0000);
        wr(`NIC_ADDR_PRIO0, 8'hCF);
        rd(`NIC_ADDR_PRIO0, 8'hCF);
        wr(`NIC_ADDR_PRIO0, 8'h64);
        rd(`NIC_ADDR_PRIO0, 8'h44);
        wr(`NIC_ADDR_PRIO3, 8'h00);
        rd(`NIC_ADDR_PRIO3, 8'hF0);
        wr(`NIC_ADDR_PRIO2, 8'hF5);
        op(nic_pkg::NIC_OP_RIM);
        chk(16'(cur), 16'h0002);
        @(posedge core_clk);
        periph_flag <= 14'h0300;
        cyc(5);
        chk(16'(int_req), 16'h0000);
        op(nic_pkg::NIC_OP_SIM);
        chk(16'(cur), 16'h0003);
        @(posedge core_clk);
        periph_en <= 14'h0300;
        cyc(5);
        chk(16'(int_req), 16'h0000);
        op(nic_pkg::NIC_OP_RIM);
        want(4'h8);
        take(4'h8, 2'h1);
        wr(`NIC_ADDR_PRIO2, 8'hF1);
        cyc(5);
        chk(16'(int_req), 16'h0000);
        wr(`NIC_ADDR_CTRL, 8'h01);
        want(4'h9);
        take(4'h9, 2'h0);
        @(posedge core_clk);
        periph_flag <= 14'h0000;
        op(nic_pkg::NIC_OP_IRQ_RETURN_INSTR);
        chk(16'(cur), 16'h0001);
        op(nic_pkg::NIC_OP_IRQ_RETURN_INSTR);
        chk(16'({int_req, cur}), 16'h0002);
        pop_code <= 2'h1;
        op(nic_pkg::NIC_OP_POPCC);
        chk(16'(cur), 16'h0001);
        slow <= 1'h1;
        op(nic_pkg::NIC_OP_SIM);
        op(nic_pkg::NIC_OP_TRAP);
        want(4'hE);
        chk(16'(int_push), 16'h0001);
        take(4'hE, 2'h3);
        op(nic_pkg::NIC_OP_IRQ_RETURN_INSTR);
        slow <= 1'h0;
        ext_pin_sel <= 16'h0002;
        wr(`NIC_ADDR_SENSE, 8'h01);
        rd(`NIC_ADDR_SENSE, 8'h01);
        ext_pin     <= 16'hFFFE;
        cyc(2);
        @(posedge core_clk);
        ext_pin <= 16'hFFFF;
        op(nic_pkg::NIC_OP_RIM);
        cyc(4);
        chk(16'(int_req), 16'h0000);
        @(posedge core_clk);
        ext_pin <= 16'hFFFD;
        cyc(2);
        @(posedge core_clk);
        ext_pin <= 16'hFFFF;
        want(4'h2);
        take(4'h2, 2'h0);
        cyc(3);
        chk(16'(int_req), 16'h0000);
        wr(`NIC_ADDR_SENSE, 8'hFF);
        rd(`NIC_ADDR_SENSE, 8'h01);
        op(nic_pkg::NIC_OP_IRQ_RETURN_INSTR);
        wr(`NIC_ADDR_PRIO2, 8'hF3);
        op(nic_pkg::NIC_OP_WFI);
        chk(16'({core_run, cur}), 16'h0002);
        @(posedge core_clk);
        periph_flag <= 14'h0200;
        want(4'h9);
        chk(16'(core_run), 16'h0001);
        take(4'h9, 2'h0);
        @(posedge core_clk);
        periph_flag <= 14'h0000;
        op(nic_pkg::NIC_OP_IRQ_RETURN_INSTR);
        ext_pin_sel <= 16'h0012;
        op(nic_pkg::NIC_OP_HALT);
        chk(16'({core_run, cur}), 16'h0002);
        @(posedge core_clk);
        periph_flag <= 14'h0100;
        cyc(6);
        chk(16'(core_run), 16'h0000);
        @(posedge core_clk);
        ext_pin <= 16'hFFEF;
        cyc(2);
        @(posedge core_clk);
        ext_pin <= 16'hFFFF;
        want(4'h3);
        take(4'h3, 2'h1);
        want(4'h8);
        op(nic_pkg::NIC_OP_HALT);
        chk(16'(core_run), 16'h0000);
        @(posedge core_clk);
        rst_n <= 1'h0;
        cyc(2);
        chk(16'(core_run), 16'h0001);
        @(posedge core_clk);
        rst_n <= 1'h1;
        cyc(2);
        chk(16'({int_req, int_vec}), 16'h001F);
        finish_test();
    end
endmodule : test_nic_ctrl
